/* dpco_pkg.sv */
package dpco_pkg;

   // Base clock and duty scaling: full scale 32000 means always high
   localparam logic [31:0] CLK_HZ     = 32'h0BEBC200;
   localparam logic [31:0] DUTY_FULL  = 32'h00007D00;
   localparam logic [31:0] DUTY_SCALE = CLK_HZ / DUTY_FULL;
   localparam logic [31:0] STEP_ONE   = 32'h00000001;

   // Register byte offsets
   localparam logic [7:0] A_MODE      = 8'h00;
   localparam logic [7:0] A_CMD       = 8'h04;
   localparam logic [7:0] A_STATUS    = 8'h08;
   localparam logic [7:0] A_DUTY1     = 8'h0C;
   localparam logic [7:0] A_FREQ1     = 8'h10;
   localparam logic [7:0] A_DUTY2     = 8'h14;
   localparam logic [7:0] A_FREQ2     = 8'h18;
   localparam logic [7:0] A_PRESET1   = 8'h1C;
   localparam logic [7:0] A_PRESET2   = 8'h20;
   localparam logic [7:0] A_STOP_PRS  = 8'h24;
   localparam logic [7:0] A_STOP_PER  = 8'h28;
   localparam logic [7:0] A_STOP_DTY1 = 8'h2C;
   localparam logic [7:0] A_STOP_DTY2 = 8'h30;
   localparam logic [7:0] A_CPR       = 8'h34;
   localparam logic [7:0] A_ACC1      = 8'h38;
   localparam logic [7:0] A_ACC2      = 8'h3C;
   localparam logic [7:0] A_ACC3      = 8'h40;
   localparam logic [7:0] A_ACC4      = 8'h44;

   // Mode register fields
   localparam int MODE_CH_W   = 2;
   localparam int MODE_OUTBIT = 4;
   localparam int MODE_STOP   = 8;
   localparam int MODE_HOLD   = 9;
   localparam int MODE_QUAD   = 11;
   localparam int MODE_W      = 13;
   localparam logic [MODE_W-1:0] MODE_RST = 13'h0000;

   // Status register fields
   localparam int STAT_OUT = 0;
   localparam int STAT_RUN = 2;

   localparam logic [31:0] WORD_RST = 32'h00000000;

   typedef enum logic [1:0] {
      DPCO_PLAIN = 2'h0,
      DPCO_PWM   = 2'h1,
      DPCO_CMP   = 2'h2
   } dpco_mode_t;

   typedef enum logic [3:0] {
      DPCO_ST_IDLE  = 4'h1,
      DPCO_ST_WDATA = 4'h2,
      DPCO_ST_RWAIT = 4'h4,
      DPCO_ST_RDATA = 4'h8
   } dpco_bus_st_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
   } dpco_req_t;

   typedef struct packed {
      logic        force_hi;
      logic [31:0] prescale;
      logic [31:0] step;
      logic [31:0] limit;
      logic [31:0] thresh;
   } dpco_cfg_t;

endpackage

/* dpco_top.sv */
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// What this block does
// - Each output selects plain, pulse-width or counter-compare mode on its own.
// - Plain mode drives each output from its stored output bit.
// - Compare mode drives output from counter total against its preset.
// - Each pulse-width generator drives its output and is enabled alone.
// - Both pulse-width channels enabled share one common frequency.
// - Shared channels start every period on the same edge.
// - Each channel keeps its own duty value.
// - Duty count sets how many ticks the output stays high per period.
// - In stop mode, tick length comes from a programmable prescaler on the base clock; run mode ticks on every clock.
// - Duty ratio equals duty count over period count.
// - Below full duty, output stays low until period and duty are both non-zero.
// - Stop mode either holds last state or runs stop prescale, period, duty.
// - Zero stop period or duty holds output low during stop.
// - Each channel has a 32-bit duty and a 32-bit frequency register.
// - Frequency is in hertz; duty 16000 gives half duty.
// - Duty 32000 holds the output high regardless of frequency.
// - Duty zero holds the output low regardless of frequency.
// - Third clear command clears counter three or quadrature pair two.
// - Fourth command clears counter four or sets quadrature pair two.
// - Zero preset disables compare and holds output low.
// - Quadrature set loads counts-per-revolution minus one.
module dpco_top (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic [3:0]  fast_pulse_counter,
   output logic             first_dedicated_output,
   output logic             second_dedicated_output
);

   localparam int NCH  = 2;
   localparam int NCNT = 4;

   // Bus slave state
   dpco_pkg::dpco_bus_st_t st_q, st_d;
   dpco_pkg::dpco_req_t    req_q, req_d;
   logic                   rdy_q, rdy_d;
   logic [31:0]            rdat_q, rdat_d;
   logic                   rsp_q;

   // Register file
   logic [dpco_pkg::MODE_W-1:0] mode_q, mode_d;
   logic [31:0] duty_q [NCH];
   logic [31:0] duty_d [NCH];
   logic [31:0] freq_q [NCH];
   logic [31:0] freq_d [NCH];
   logic [31:0] pre_q  [NCH];
   logic [31:0] pre_d  [NCH];
   logic [31:0] sdty_q [NCH];
   logic [31:0] sdty_d [NCH];
   logic [31:0] sprs_q, sprs_d;
   logic [31:0] sper_q, sper_d;
   logic [31:0] cpr_q, cpr_d;
   logic [NCNT-1:0] cmd_q, cmd_d;

   // Engines and counters
   logic [31:0]           acc_q  [NCH];
   logic [31:0]           acc_d  [NCH];
   logic [31:0]           pcnt_q [NCH];
   logic [31:0]           pcnt_d [NCH];
   dpco_pkg::dpco_cfg_t   act_q  [NCH];
   dpco_pkg::dpco_cfg_t   act_d  [NCH];
   logic [NCH-1:0]        run_q, run_d;
   logic [NCH-1:0]        wrap;
   logic [NCH-1:0]        out_q, out_d;
   logic [31:0]           cnt_q  [NCNT];
   logic [31:0]           cnt_d  [NCNT];
   logic [NCNT-1:0]       s1_q, s2_q, s3_q;

   logic                  stop;
   logic                  shared;
   logic                  accept;

   assign stop   = mode_q[dpco_pkg::MODE_STOP];
   assign accept = hsel && htrans[1] && hready;

   // The bus only passes single word transfers, so hsize is not decoded
   always_comb begin
      st_d   = st_q;
      req_d  = req_q;
      rdat_d = rdat_q;
      unique case (st_q)
         dpco_pkg::DPCO_ST_RWAIT: begin
            // One wait state so a read sees a write made just before it
            st_d = dpco_pkg::DPCO_ST_RDATA;
            case (req_q.addr)
               dpco_pkg::A_MODE:      rdat_d = 32'(mode_q);
               dpco_pkg::A_STATUS:    rdat_d = 32'({run_q, out_q});
               dpco_pkg::A_DUTY1:     rdat_d = duty_q[0];
               dpco_pkg::A_FREQ1:     rdat_d = freq_q[0];
               dpco_pkg::A_DUTY2:     rdat_d = duty_q[1];
               dpco_pkg::A_FREQ2:     rdat_d = freq_q[1];
               dpco_pkg::A_PRESET1:   rdat_d = pre_q[0];
               dpco_pkg::A_PRESET2:   rdat_d = pre_q[1];
               dpco_pkg::A_STOP_PRS:  rdat_d = sprs_q;
               dpco_pkg::A_STOP_PER:  rdat_d = sper_q;
               dpco_pkg::A_STOP_DTY1: rdat_d = sdty_q[0];
               dpco_pkg::A_STOP_DTY2: rdat_d = sdty_q[1];
               dpco_pkg::A_CPR:       rdat_d = cpr_q;
               dpco_pkg::A_ACC1:      rdat_d = cnt_q[0];
               dpco_pkg::A_ACC2:      rdat_d = cnt_q[1];
               dpco_pkg::A_ACC3:      rdat_d = cnt_q[2];
               dpco_pkg::A_ACC4:      rdat_d = cnt_q[3];
               default:               rdat_d = dpco_pkg::WORD_RST;
            endcase
         end
         dpco_pkg::DPCO_ST_IDLE,
         dpco_pkg::DPCO_ST_WDATA,
         dpco_pkg::DPCO_ST_RDATA: begin
            if (accept) begin
               req_d.addr = haddr[7:0];
               req_d.wr   = hwrite;
               st_d       = hwrite ? dpco_pkg::DPCO_ST_WDATA : dpco_pkg::DPCO_ST_RWAIT;
            end else begin
               st_d = dpco_pkg::DPCO_ST_IDLE;
            end
         end
      endcase
      rdy_d = (st_d != dpco_pkg::DPCO_ST_RWAIT);
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         st_q   <= dpco_pkg::DPCO_ST_IDLE;
         req_q  <= '0;
         rdy_q  <= 1'b1;
         rdat_q <= dpco_pkg::WORD_RST;
         rsp_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         req_q  <= req_d;
         rdy_q  <= rdy_d;
         rdat_q <= rdat_d;
         rsp_q  <= 1'b0;
      end
   end

   assign hreadyout = rdy_q;
   assign hrdata    = rdat_q;
   // Response leaves a flop too; it never signals an error
   assign hresp     = rsp_q;

   // Register writes; command bits are one-cycle pulses
   always_comb begin
      mode_d = mode_q;
      duty_d = duty_q;
      freq_d = freq_q;
      pre_d  = pre_q;
      sdty_d = sdty_q;
      sprs_d = sprs_q;
      sper_d = sper_q;
      cpr_d  = cpr_q;
      cmd_d  = '0;
      if (st_q == dpco_pkg::DPCO_ST_WDATA) begin
         case (req_q.addr)
            dpco_pkg::A_MODE:      mode_d    = hwdata[dpco_pkg::MODE_W-1:0];
            dpco_pkg::A_CMD:       cmd_d     = hwdata[NCNT-1:0];
            dpco_pkg::A_DUTY1:     duty_d[0] = hwdata;
            dpco_pkg::A_FREQ1:     freq_d[0] = hwdata;
            dpco_pkg::A_DUTY2:     duty_d[1] = hwdata;
            dpco_pkg::A_FREQ2:     freq_d[1] = hwdata;
            dpco_pkg::A_PRESET1:   pre_d[0]  = hwdata;
            dpco_pkg::A_PRESET2:   pre_d[1]  = hwdata;
            dpco_pkg::A_STOP_PRS:  sprs_d    = hwdata;
            dpco_pkg::A_STOP_PER:  sper_d    = hwdata;
            dpco_pkg::A_STOP_DTY1: sdty_d[0] = hwdata;
            dpco_pkg::A_STOP_DTY2: sdty_d[1] = hwdata;
            dpco_pkg::A_CPR:       cpr_d     = hwdata;
            // Status and accumulators are read only, so writes to them are dropped
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         mode_q <= dpco_pkg::MODE_RST;
         duty_q <= '{default: dpco_pkg::WORD_RST};
         freq_q <= '{default: dpco_pkg::WORD_RST};
         pre_q  <= '{default: dpco_pkg::WORD_RST};
         sdty_q <= '{default: dpco_pkg::WORD_RST};
         sprs_q <= dpco_pkg::WORD_RST;
         sper_q <= dpco_pkg::WORD_RST;
         cpr_q  <= dpco_pkg::WORD_RST;
         cmd_q  <= '0;
      end else begin
         mode_q <= mode_d;
         duty_q <= duty_d;
         freq_q <= freq_d;
         pre_q  <= pre_d;
         sdty_q <= sdty_d;
         sprs_q <= sprs_d;
         sper_q <= sper_d;
         cpr_q  <= cpr_d;
         cmd_q  <= cmd_d;
      end
   end

   // Both in pulse-width mode: channel two rides channel one's timebase
   assign shared = (mode_q[dpco_pkg::MODE_CH_W-1:0] == dpco_pkg::DPCO_PWM)
                && (mode_q[dpco_pkg::MODE_CH_W +: dpco_pkg::MODE_CH_W] == dpco_pkg::DPCO_PWM);

   for (genvar i = 0; i < NCH; i++) begin : g_ch
      dpco_pkg::dpco_mode_t md;
      dpco_pkg::dpco_cfg_t  sel;
      logic                 sel_ok;
      logic                 pwm_en;
      logic                 hold;
      logic                 tick;
      logic                 pwm_hi;
      logic                 cmp_hi;
      logic [32:0]          sum;
      logic [31:0]          fsrc;

      assign md     = dpco_pkg::dpco_mode_t'(mode_q[i*dpco_pkg::MODE_CH_W +: dpco_pkg::MODE_CH_W]);
      assign pwm_en = (md == dpco_pkg::DPCO_PWM);
      assign hold   = stop && mode_q[dpco_pkg::MODE_HOLD + i];
      assign fsrc   = shared ? freq_q[0] : freq_q[i];

      // Run mode counts the base clock in hertz steps, wrapping at CLK_HZ
      always_comb begin
         sel    = '0;
         sel_ok = 1'b0;
         if (!stop) begin
            sel.step     = fsrc;
            sel.limit    = dpco_pkg::CLK_HZ;
            sel.force_hi = (duty_q[i] >= dpco_pkg::DUTY_FULL);
            sel.thresh   = 32'(duty_q[i] * dpco_pkg::DUTY_SCALE);
            sel_ok       = sel.force_hi
                        || ((duty_q[i] != '0) && (fsrc != '0)
                        && (fsrc <= dpco_pkg::CLK_HZ));
         end else begin
            sel.prescale = sprs_q;
            sel.step     = dpco_pkg::STEP_ONE;
            sel.limit    = sper_q;
            sel.thresh   = sdty_q[i];
            sel_ok       = (sper_q != '0) && (sdty_q[i] != '0);
         end
      end

      // Run mode leaves the prescale at zero, so it ticks on every clock
      assign tick = (pcnt_q[i] == act_q[i].prescale);
      assign sum  = {1'b0, acc_q[i]} + {1'b0, act_q[i].step};
      if (i == 0) begin : g_own
         assign wrap[i] = tick && (sum >= {1'b0, act_q[i].limit});
      end else begin : g_dep
         assign wrap[i] = shared ? wrap[0]
                        : (tick && (sum >= {1'b0, act_q[i].limit}));
      end

      always_comb begin
         acc_d[i]  = acc_q[i];
         pcnt_d[i] = pcnt_q[i];
         act_d[i]  = act_q[i];
         run_d[i]  = run_q[i];
         // An invalid setting stops the channel at once, not at a period edge
         if (!pwm_en || (!hold && !sel_ok)) begin
            run_d[i]  = 1'b0;
            acc_d[i]  = '0;
            pcnt_d[i] = '0;
         end else if (!hold) begin
            if (tick) begin
               pcnt_d[i] = '0;
               acc_d[i]  = wrap[i] ? 32'(sum - {1'b0, act_q[i].limit}) : sum[31:0];
            end else begin
               pcnt_d[i] = pcnt_q[i] + 32'h00000001;
            end
            // Settings are taken only at a period edge so no pulse is cut short
            if (!run_q[i] || wrap[i]) begin
               act_d[i] = sel;
            end
            if (!run_q[i]) begin
               acc_d[i]  = '0;
               pcnt_d[i] = '0;
            end
            run_d[i] = 1'b1;
         end
         if ((i != 0) && shared && !hold) begin
            acc_d[i]  = acc_d[0];
            pcnt_d[i] = pcnt_d[0];
         end
      end

      assign pwm_hi = run_q[i] && (act_q[i].force_hi || (acc_q[i] < act_q[i].thresh));
      assign cmp_hi = (pre_q[i] != '0) && (cnt_q[i] >= pre_q[i]);

      always_comb begin
         case (md)
            dpco_pkg::DPCO_PLAIN: out_d[i] = mode_q[dpco_pkg::MODE_OUTBIT + i];
            dpco_pkg::DPCO_PWM:   out_d[i] = pwm_hi;
            dpco_pkg::DPCO_CMP:   out_d[i] = cmp_hi;
            default:              out_d[i] = 1'b0;
         endcase
      end

      always_ff @(posedge sys_clk) begin
         if (!reset_n) begin
            acc_q[i]  <= dpco_pkg::WORD_RST;
            pcnt_q[i] <= dpco_pkg::WORD_RST;
            act_q[i]  <= '0;
            run_q[i]  <= 1'b0;
            out_q[i]  <= 1'b0;
         end else begin
            acc_q[i]  <= acc_d[i];
            pcnt_q[i] <= pcnt_d[i];
            act_q[i]  <= act_d[i];
            run_q[i]  <= run_d[i];
            out_q[i]  <= out_d[i];
         end
      end
   end

   assign first_dedicated_output  = out_q[0];
   assign second_dedicated_output = out_q[1];

   // Counter inputs are simple totalizers; quadrature decoding is not modelled
   for (genvar k = 0; k < NCNT; k++) begin : g_cnt
      logic quad;
      logic edge_in;

      assign quad    = mode_q[dpco_pkg::MODE_QUAD + k/2];
      // Third flop only delays for the edge detector; all reset low like idle pins
      assign edge_in = s2_q[k] && !s3_q[k];

      if (k % 2 == 0) begin : g_even
         always_comb begin
            cnt_d[k] = cnt_q[k] + {31'h00000000, edge_in};
            if (cmd_q[k]) begin
               cnt_d[k] = '0;
            end else if (quad && cmd_q[k+1]) begin
               cnt_d[k] = cpr_q - 32'h00000001;
            end
         end
      end else begin : g_odd
         // In quadrature this bit sets the even partner instead of clearing here
         always_comb begin
            cnt_d[k] = cnt_q[k] + {31'h00000000, edge_in};
            if (cmd_q[k] && !quad) begin
               cnt_d[k] = '0;
            end
         end
      end

      always_ff @(posedge sys_clk) begin
         if (!reset_n) begin
            s1_q[k]  <= 1'b0;
            s2_q[k]  <= 1'b0;
            s3_q[k]  <= 1'b0;
            cnt_q[k] <= dpco_pkg::WORD_RST;
         end else begin
            s1_q[k]  <= fast_pulse_counter[k];
            s2_q[k]  <= s1_q[k];
            s3_q[k]  <= s2_q[k];
            cnt_q[k] <= cnt_d[k];
         end
      end
   end

endmodule

/* dpco_monitor.sv */
`timescale 1ns/1ps
module dpco_monitor (
   input wire logic        sys_clk,
   input wire logic        reset_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   input wire logic        first_dedicated_output,
   input wire logic        second_dedicated_output
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   wire logic tk = hsel && htrans[1] && hready;

   AST_OKAY: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   AST_RD_WAIT: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   AST_WR_NOWAIT: assert property (tk && hwrite |=> hreadyout)
      else $error("write stalled");
   AST_LOW_ONE: assert property ($fell(hreadyout) |=> $rose(hreadyout))
      else $error("ready low too long");
   AST_RST: assert property ($rose(reset_n) |-> hreadyout && hrdata == 32'h00000000
      && !first_dedicated_output && !second_dedicated_output)
      else $error("state after reset wrong");
   // Read data may only move when a read completes, so a snapshot never tears
   AST_SNAP: assert property ($changed(hrdata) |-> $rose(hreadyout))
      else $error("read data moved outside a read");
   AST_NULL_RD: assert property (tk && !hwrite && (haddr[7:0] == dpco_pkg::A_CMD
      || haddr[7:0] > dpco_pkg::A_ACC4) |-> ##2 hrdata == 32'h00000000)
      else $error("empty location read not zero");
   AST_PLAIN: assert property (tk && hwrite && haddr[7:0] == dpco_pkg::A_MODE
      ##1 hwdata[3:0] == 4'h0 |-> ##2 first_dedicated_output == $past(hwdata[4], 2)
      && second_dedicated_output == $past(hwdata[5], 2))
      else $error("plain output not from stored bit");
endmodule

bind dpco_top dpco_monitor i_mon (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hreadyout, .hrdata, .hresp, .first_dedicated_output,
   .second_dedicated_output);

/* dpco_load.sv */
`timescale 1ns/1ps
// Resistive load on both outputs: it only integrates what it sees each cycle
module dpco_load (
   input wire logic sys_clk,
   input wire logic load_a,
   input wire logic load_b,
   output int       hi_a = 0,
   output int       hi_b = 0,
   output int       lone_b = 0,
   output int       rise_a = 0
);
   logic prev_a = 1'b0;
   always @(posedge sys_clk) begin
      hi_a <= hi_a + int'(load_a);
      hi_b <= hi_b + int'(load_b);
      lone_b <= lone_b + int'(load_b && !load_a);
      rise_a <= rise_a + int'(load_a && !prev_a);
      prev_a <= load_a;
   end
endmodule

/* dpco_tb.sv */
`timescale 1ns/1ps
module tb;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        hsel = 1'b1;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic [3:0]  pins = 4'h0;
   logic        hreadyout;
   logic        hresp;
   logic        out_a;
   logic        out_b;
   logic [31:0] hrdata;
   logic [31:0] sq;
   int          hi_a, hi_b, lone_b, rise_a, da, db, dl, dr, r;
   int          err_count = 0;
   int          num_checks = 0;
   int          seed = 93832;
   int          regm [18];
   int          acc [4];

   dpco_top i_dut (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .fast_pulse_counter(pins),
      .first_dedicated_output(out_a), .second_dedicated_output(out_b));
   dpco_load i_load (.sys_clk, .load_a(out_a), .load_b(out_b), .hi_a, .hi_b, .lone_b,
      .rise_a);

   initial forever #2.5 sys_clk = ~sys_clk;

   task automatic tally_and_finish;
      if (err_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
      if (a == dpco_pkg::A_MODE) regm[0] = d & 32'h00001FFF;
      else if (a >= dpco_pkg::A_DUTY1 && a <= dpco_pkg::A_CPR) regm[a[7:2]] = d;
      else if (a == dpco_pkg::A_CMD) begin
         for (int i = 0; i < 4; i++) begin
            if (d[i] && i % 2 == 1 && regm[0][11 + i / 2]) begin
               if (!d[i - 1]) acc[i - 1] = regm[13] - 1;
            end else if (d[i]) acc[i] = 0;
         end
      end
   endtask

   task automatic rc(input logic [7:0] a, input string nm);
      logic [31:0] q;
      logic [31:0] e;
      bus(a, 1'b0, $random(seed), q);
      e = 32'h00000000;
      if (a < dpco_pkg::A_ACC1) e = regm[a[7:2]];
      else if (a <= dpco_pkg::A_ACC4) e = acc[a[7:2] - 14];
      chk(nm, q, e);
   endtask

   task automatic pulse(input int i, input int n);
      repeat (n) begin
         pins[i] <= 1'b1;
         cyc(3);
         pins[i] <= 1'b0;
         cyc(3);
      end
      acc[i] += n;
   endtask

   // Windows are whole multiples of every period used, so counts are exact
   task automatic win;
      cyc(40);
      da = hi_a;
      db = hi_b;
      dl = lone_b;
      dr = rise_a;
      cyc(400);
      da = hi_a - da;
      db = hi_b - db;
      dl = lone_b - dl;
      dr = rise_a - dr;
   endtask

   initial begin
      cyc(20);
      reset_n <= 1'b1;
      cyc(1);
      for (int a = 0; a < 19; a++) if (a != 2) rc(8'(a * 4), "reset value");
      for (int a = 3; a < 19; a++) wr(8'(a * 4), $random(seed));
      for (int a = 3; a < 19; a++) rc(8'(a * 4), "read back");
      for (int m = 0; m < 4; m++) begin
         wr(dpco_pkg::A_MODE, 32'(m << 4));
         cyc(3);
         chk("plain outputs", {30'h0, out_b, out_a}, 32'(m));
      end
      wr(dpco_pkg::A_DUTY1, 32'h00003E80);
      wr(dpco_pkg::A_DUTY2, 32'h00001F40);
      wr(dpco_pkg::A_FREQ2, 32'h002DC6C0);
      wr(dpco_pkg::A_FREQ1, 32'h00000000);
      wr(dpco_pkg::A_MODE, 32'h00000005);
      win;
      chk("idle high count", 32'(da + db), 32'h00000000);
      wr(dpco_pkg::A_FREQ1, 32'h00989680);
      win;
      chk("ch1 high count", 32'(da), 32'h000000C8);
      chk("ch2 high count", 32'(db), 32'h00000064);
      chk("ch2 alone high", 32'(dl), 32'h00000000);
      chk("ch1 period", 32'(dr), 32'h00000014);
      r = 1 + {$random(seed)} % 19;
      wr(dpco_pkg::A_DUTY1, 32'(1600 * r));
      win;
      chk("random duty", 32'(da), 32'(20 * r));
      wr(dpco_pkg::A_DUTY1, 32'h00003E80);
      wr(dpco_pkg::A_MODE, 32'h00000021);
      win;
      chk("independent ch1", 32'(da), 32'h000000C8);
      chk("plain ch2", 32'(db), 32'h00000190);
      wr(dpco_pkg::A_MODE, 32'h00000005);
      wr(dpco_pkg::A_DUTY1, 32'h00007D00);
      wr(dpco_pkg::A_DUTY2, 32'h00000000);
      win;
      chk("full duty", 32'(da), 32'h00000190);
      chk("zero duty", 32'(db), 32'h00000000);
      bus(dpco_pkg::A_STATUS, 1'b0, 32'h00000000, sq);
      chk("status", sq, 32'h00000005);
      wr(dpco_pkg::A_STOP_PRS, 32'h00000000);
      wr(dpco_pkg::A_STOP_PER, 32'h0000000A);
      wr(dpco_pkg::A_STOP_DTY1, 32'h00000004);
      wr(dpco_pkg::A_STOP_DTY2, 32'h00000000);
      wr(dpco_pkg::A_MODE, 32'h00000105);
      win;
      chk("stop duty", 32'(da), 32'h000000A0);
      chk("stop zero duty", 32'(db), 32'h00000000);
      wr(dpco_pkg::A_MODE, 32'h00000305);
      win;
      chk("stop hold edges", 32'(dr), 32'h00000000);
      wr(dpco_pkg::A_PRESET1, 32'h00000003);
      wr(dpco_pkg::A_PRESET2, 32'h00000000);
      wr(dpco_pkg::A_CMD, 32'h0000000F);
      wr(dpco_pkg::A_MODE, 32'h0000000A);
      pulse(0, 2);
      cyc(6);
      chk("below preset", {31'h0, out_a}, 32'h00000000);
      pulse(0, 1);
      cyc(6);
      chk("at preset", {31'h0, out_a}, 32'h00000001);
      pulse(1, 5);
      pulse(2, 2);
      pulse(3, 1);
      cyc(6);
      chk("zero preset", {31'h0, out_b}, 32'h00000000);
      for (int i = 14; i < 18; i++) rc(8'(i * 4), "count");
      wr(dpco_pkg::A_CMD, 32'h0000000F);
      cyc(2);
      for (int i = 14; i < 18; i++) rc(8'(i * 4), "cleared");
      wr(dpco_pkg::A_CPR, 32'h00000064);
      wr(dpco_pkg::A_MODE, 32'h0000100A);
      pulse(3, 2);
      cyc(6);
      wr(dpco_pkg::A_CMD, 32'h00000008);
      cyc(2);
      rc(dpco_pkg::A_ACC3, "quad set");
      rc(dpco_pkg::A_ACC4, "quad pair kept");
      rc(dpco_pkg::A_MODE, "mode read back");
      tally_and_finish;
   end

   initial begin
      cyc(30000);
      err_count++;
      tally_and_finish;
   end
endmodule
